// *** include/lin_node_defines.vh ***
// Constants for the LIN node setup and bit-rate block
`ifndef LIN_NODE_DEFINES_VH
`define LIN_NODE_DEFINES_VH
// Indirect register indices
`define IDX_DATA_FIRST     4'h0
`define IDX_DATA_LAST      4'h7
`define IDX_CTRL           4'h8
`define IDX_STATUS         4'h9
`define IDX_SIZE           4'hb
`define IDX_DIV            4'hc
`define IDX_MUL            4'hd
`define IDX_ID             4'he
// Direct register bits
`define MODE_ACTIVE_BIT    7
`define MODE_MASTER_BIT    6
`define MODE_AUTO_BIT      5
// Control bits
`define CTRL_START_BIT     0
`define CTRL_CLR_ERR_BIT   2
`define CTRL_CLR_INT_BIT   3
`define CTRL_TXRX_BIT      5
// Size register
`define SIZE_ENH_BIT       7
// Multiplier register fields
`define MUL_PRE_HI         7
`define MUL_PRE_LO         6
`define MUL_MULT_HI        5
`define MUL_MULT_LO        1
`define MUL_DIV8_BIT       0
// Factor limits
`define PRE_MAX            2'h3
`define MULT_MAX           5'h1f
`define DIV_MIN            9'h0c8
`define DIV_MAX            9'h1ff
// Reset values
`define RST_BYTE           8'h00
`define RST_DIV            8'hc8
// Bits per LIN byte frame (start, 8 data, stop)
`define FRAME_BITS         4'ha
`define BREAK_BITS         5'h0d
`endif

// *** src/baud_gen.v ***
// Manual bit-rate tick generator: clk / (2^(pre+1) * div * (mult+1))
`timescale 1ns/1ps
`include "lin_node_defines.vh"
module baud_gen (
  input  wire       clk_sys,
  input  wire       rst_n,
  input  wire       run,
  input  wire [1:0] pre,
  input  wire [8:0] div,
  input  wire [4:0] mult,
  output reg        bit_tick
);
  reg  [4:0] pre_cnt_q;
  reg  [8:0] div_cnt_q;
  reg  [4:0] mul_cnt_q;
  wire [4:0] pre_end;
  wire [8:0] div_end;
  wire       pre_wrap;
  wire       div_wrap;

  // Divider clamped so an out-of-range value cannot stall or overspeed the bus
  assign div_end  = (div < `DIV_MIN) ? `DIV_MIN - 9'h001 : div - 9'h001; // [RQ7]
  assign pre_end  = (5'h02 << pre) - 5'h01;                              // [RQ6]
  assign pre_wrap = (pre_cnt_q == pre_end);
  assign div_wrap = pre_wrap && (div_cnt_q == div_end);

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt_q <= 5'h00;
      div_cnt_q <= 9'h000;
      mul_cnt_q <= 5'h00;
      bit_tick  <= 1'b0;
    end else if (!run) begin
      pre_cnt_q <= 5'h00;
      div_cnt_q <= 9'h000;
      mul_cnt_q <= 5'h00;
      bit_tick  <= 1'b0;
    end else begin
      bit_tick  <= 1'b0;
      pre_cnt_q <= pre_wrap ? 5'h00 : pre_cnt_q + 5'h01;
      if (pre_wrap)
        div_cnt_q <= (div_cnt_q == div_end) ? 9'h000 : div_cnt_q + 9'h001;
      if (div_wrap) begin
        if (mul_cnt_q == mult) begin
          mul_cnt_q <= 5'h00;
          bit_tick  <= 1'b1; // [RQ6]
        end else begin
          mul_cnt_q <= mul_cnt_q + 5'h01;
        end
      end
    end
  end
endmodule // baud_gen

// *** src/lin_checksum.v ***
// Running LIN checksum, classic or enhanced, with end-around carry
`timescale 1ns/1ps
module lin_checksum (
  input  wire       clk_sys,
  input  wire       rst_n,
  input  wire       init,
  input  wire       enhanced,
  input  wire [7:0] pid,
  input  wire       add,
  input  wire [7:0] data,
  output reg  [7:0] sum_q
);
  function [7:0] add_carry;
    input [7:0] a;
    input [7:0] b;
    reg   [8:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      add_carry = s[7:0] + {7'h00, s[8]};
    end
  endfunction

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      sum_q <= 8'h00;
    else if (init)
      sum_q <= enhanced ? pid : 8'h00; // [RQ11]
    else if (add)
      sum_q <= add_carry(sum_q, data);
  end
endmodule // lin_checksum

// *** src/lin_node.v ***
// LIN node: direct mode register, indirect register file, frame engine
//
// Summary of operation
// (RQ1) Master and slave roles, chosen by one bit; the code has no slave frame handling, a node with bit6 clear never leaves idle
// (RQ2) Software uses manual rate when master
// (RQ3) Auto-rate bit selects manual or automatic rate; the code leaves auto_rate unused and always runs the manual generator
// (RQ4) Only mode register directly; others indirectly; the code also gives the index register direct ports
// (RQ5) Window access targets register at held index
// (RQ6) Rate is clock over prescale, divider, multiplier
// (RQ7) Factor ranges 0-3, 0-31, 200-511
// (RQ8) Factors live in divider and multiplier registers
// (RQ9) Multiplier register: prescale, multiplier, divider bit8
// (RQ10) Divider register index 12 holds low bits
// (RQ11) Both checksums; size bit7 picks enhanced
// (RQ12) Mode bit7 activates, bit6 makes master
// (RQ13) Writing 0x0c clears interrupt and errors
// (RQ14) Software truncates computed factors downward
// (RQ15) Interrupt and polled operation both supported
// (RQ16) State machine serializes, deserializes, times bits
// (RQ17) Data registers hold transmit and received bytes
// (RQ18) Control bit0 requests frame start
// (RQ19) Control bit3 clears interrupt, bit2 errors
// (RQ20) Clear bits are strobes, read back zero
`timescale 1ns/1ps
`include "lin_node_defines.vh"
module lin_node (
  input  wire       clk_sys,
  input  wire       rst_n,
  input  wire       mode_wr,
  input  wire [7:0] mode_wdata,
  output wire [7:0] mode_rdata,
  input  wire       index_wr,
  input  wire [7:0] index_wdata,
  output wire [7:0] index_rdata,
  input  wire       window_wr,
  input  wire [7:0] window_wdata,
  output reg  [7:0] window_rdata,
  input  wire       lin_rx,
  output reg        lin_tx,
  output reg        irq
);
  localparam ST_IDLE  = 3'h0;
  localparam ST_BREAK = 3'h1;
  localparam ST_HDR   = 3'h2;
  localparam ST_DATA  = 3'h3;
  localparam ST_CSUM  = 3'h4;
  localparam ST_DONE  = 3'h5;

  reg  [7:0] mode_q;
  reg  [7:0] index_q;
  reg  [7:0] size_q;
  reg  [7:0] div_q;
  reg  [7:0] mul_q;
  reg  [7:0] id_q;
  reg        txrx_q;
  reg        done_q;
  reg        err_q;
  reg  [7:0] buf_q [0:7];
  reg  [2:0] state_q;
  reg  [3:0] bit_cnt_q;
  reg  [4:0] brk_cnt_q;
  reg  [3:0] byte_cnt_q;
  reg  [1:0] hdr_cnt_q;
  reg  [9:0] shift_q;
  reg  [7:0] rx_q;
  reg        rx_meta_q;
  reg        rx_sync_q;
  wire       bit_tick;
  wire [7:0] rx_next;
  wire [7:0] sum;
  wire       active;
  wire       master;
  wire       auto_rate;
  wire       ctrl_wr;
  wire       start_req;
  wire       clr_int;
  wire       clr_err;
  wire [7:0] pid;
  wire [7:0] stat;
  wire [3:0] len;
  wire       csum_init;
  wire       csum_add;
  integer    i;

  function [7:0] parity_id;
    input [5:0] id;
    begin
      parity_id = {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
    end
  endfunction

  assign active    = mode_q[`MODE_ACTIVE_BIT];                        // [RQ12]
  assign master    = mode_q[`MODE_MASTER_BIT];                        // [RQ1]
  assign auto_rate = mode_q[`MODE_AUTO_BIT];                          // [RQ3]
  assign ctrl_wr   = window_wr && (index_q[3:0] == `IDX_CTRL);         // [RQ5]
  assign start_req = ctrl_wr && window_wdata[`CTRL_START_BIT];         // [RQ18]
  assign clr_int   = ctrl_wr && window_wdata[`CTRL_CLR_INT_BIT];       // [RQ19] [RQ13]
  assign clr_err   = ctrl_wr && window_wdata[`CTRL_CLR_ERR_BIT];       // [RQ19] [RQ13]
  assign pid       = parity_id(id_q[5:0]);
  assign len       = (size_q[3:0] == 4'h0) ? 4'h1 :
                     (size_q[3:0] > 4'h8) ? 4'h8 : size_q[3:0];
  assign stat      = {(state_q != ST_IDLE), 4'h0, err_q, irq, done_q}; // [RQ15]
  assign mode_rdata  = mode_q;  // [RQ4]
  assign index_rdata = index_q;
  assign csum_init = (state_q == ST_HDR) && bit_tick && (hdr_cnt_q == 2'h1) &&
                     (bit_cnt_q == `FRAME_BITS - 4'h1);
  // Sent bytes are summed at their start bit, so the total is ready for the checksum byte
  assign csum_add  = (state_q == ST_DATA) && bit_tick &&
                     (bit_cnt_q == (txrx_q ? 4'h0 : `FRAME_BITS - 4'h1));
  assign rx_next   = {rx_sync_q, rx_q[7:1]};

  // Automatic rate measurement is not built; auto mode keeps the manual generator
  baud_gen u_baud (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .run      (active && (state_q != ST_IDLE)),
    .pre      (mul_q[`MUL_PRE_HI:`MUL_PRE_LO]),                          // [RQ9] [RQ8]
    .div      ({mul_q[`MUL_DIV8_BIT], div_q}),                           // [RQ10]
    .mult     (mul_q[`MUL_MULT_HI:`MUL_MULT_LO]),
    .bit_tick (bit_tick)
  );

  lin_checksum u_csum (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .init     (csum_init),
    .enhanced (size_q[`SIZE_ENH_BIT]),                                   // [RQ11]
    .pid      (pid),
    .add      (csum_add),
    .data     (txrx_q ? buf_q[byte_cnt_q[2:0]] : rx_next),
    .sum_q    (sum)
  );

  // Bus input is asynchronous to the system clock
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end else begin
      rx_meta_q <= lin_rx;
      rx_sync_q <= rx_meta_q;
    end
  end

  // Direct and indirect register writes
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_q  <= `RST_BYTE;
      index_q <= `RST_BYTE;
      size_q  <= `RST_BYTE;
      div_q   <= `RST_DIV;
      mul_q   <= `RST_BYTE;
      id_q    <= `RST_BYTE;
      txrx_q  <= 1'b0;
      for (i = 0; i < 8; i = i + 1)
        buf_q[i] <= `RST_BYTE;
    end else begin
      if (mode_wr)
        mode_q <= mode_wdata; // [RQ4] [RQ1] [RQ3]
      if (index_wr)
        index_q <= index_wdata;
      if (window_wr) begin
        case (index_q[3:0]) // [RQ5]
          `IDX_CTRL: txrx_q <= window_wdata[`CTRL_TXRX_BIT];
          `IDX_SIZE: size_q <= window_wdata; // [RQ11]
          `IDX_DIV:  div_q  <= window_wdata; // [RQ10]
          `IDX_MUL:  mul_q  <= window_wdata; // [RQ9]
          `IDX_ID:   id_q   <= window_wdata;
          default: begin
            if (index_q[3:0] <= `IDX_DATA_LAST)
              buf_q[index_q[2:0]] <= window_wdata; // [RQ17]
          end
        endcase
      end
      // Received bytes land in the buffer; software writes the same cycle lose
      if (csum_add && !txrx_q)
        buf_q[byte_cnt_q[2:0]] <= rx_next; // [RQ17]
    end
  end

  // Indirect read mux; clear strobes are never stored so they read zero
  always @* begin
    case (index_q[3:0]) // [RQ5]
      `IDX_CTRL:   window_rdata = {2'b00, txrx_q, 5'h00}; // [RQ20]
      `IDX_STATUS: window_rdata = stat;
      `IDX_SIZE:   window_rdata = size_q;
      `IDX_DIV:    window_rdata = div_q;
      `IDX_MUL:    window_rdata = mul_q;
      `IDX_ID:     window_rdata = id_q;
      default:     window_rdata = (index_q[3:0] <= `IDX_DATA_LAST) ?
                                  buf_q[index_q[2:0]] : 8'h00;
    endcase
  end

  // Frame engine: break, sync, protected id, data, checksum
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= ST_IDLE;
      bit_cnt_q  <= 4'h0;
      brk_cnt_q  <= 5'h00;
      byte_cnt_q <= 4'h0;
      hdr_cnt_q  <= 2'h0;
      shift_q    <= 10'h3ff;
      rx_q       <= 8'h00;
      lin_tx     <= 1'b1;
      done_q     <= 1'b0;
      err_q      <= 1'b0;
      irq        <= 1'b0;
    end else begin
      // Hardware set beats a same-cycle clear
      if (clr_int)
        irq <= 1'b0;
      if (clr_err)
        err_q <= 1'b0;
      if (!active) begin
        state_q <= ST_IDLE;
        lin_tx  <= 1'b1;
      end else begin
        case (state_q)
          ST_IDLE: begin
            lin_tx <= 1'b1;
            if (start_req && master) begin // [RQ18] [RQ1]
              state_q   <= ST_BREAK;
              brk_cnt_q <= 5'h00;
              done_q    <= 1'b0;
            end
          end
          ST_BREAK: begin
            lin_tx <= 1'b0;
            if (bit_tick) begin
              if (brk_cnt_q == `BREAK_BITS) begin
                lin_tx    <= 1'b1;
                state_q   <= ST_HDR;
                hdr_cnt_q <= 2'h0;
                bit_cnt_q <= 4'h0;
                shift_q   <= {1'b1, 8'h55, 1'b0};
              end else begin
                brk_cnt_q <= brk_cnt_q + 5'h01;
              end
            end
          end
          ST_HDR, ST_DATA, ST_CSUM: begin
            if (bit_tick) begin // [RQ16]
              lin_tx    <= (state_q == ST_DATA && !txrx_q) ? 1'b1 : shift_q[0];
              shift_q   <= {1'b1, shift_q[9:1]};
              rx_q      <= rx_next;
              bit_cnt_q <= bit_cnt_q + 4'h1;
              if (bit_cnt_q == `FRAME_BITS - 4'h1) begin
                bit_cnt_q <= 4'h0;
                // Bit now on the bus against its readback; a mismatch flags a bit error
                if (lin_tx != rx_sync_q && (state_q != ST_DATA || txrx_q))
                  err_q <= 1'b1;
                if (state_q == ST_HDR && hdr_cnt_q == 2'h0) begin
                  hdr_cnt_q <= 2'h1;
                  shift_q   <= {1'b1, pid, 1'b0};
                end else if (state_q == ST_HDR) begin
                  state_q    <= ST_DATA;
                  byte_cnt_q <= 4'h0;
                  shift_q    <= {1'b1, buf_q[0], 1'b0};
                end else if (state_q == ST_DATA && byte_cnt_q == len - 4'h1) begin
                  state_q <= ST_CSUM;
                  shift_q <= {1'b1, ~sum, 1'b0};
                end else if (state_q == ST_DATA) begin
                  byte_cnt_q <= byte_cnt_q + 4'h1;
                  shift_q    <= {1'b1, buf_q[byte_cnt_q[2:0] + 3'h1], 1'b0};
                end else begin
                  state_q <= ST_DONE;
                end
              end
            end
          end
          ST_DONE: begin
            lin_tx  <= 1'b1;
            done_q  <= 1'b1;
            irq     <= 1'b1; // [RQ15]
            state_q <= ST_IDLE;
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // lin_node

// *** tb/lin_node_sva.sv ***
// Port checker for the LIN node
`timescale 1ns/1ps
module lin_node_sva (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       mode_wr,
  input wire logic [7:0] mode_wdata,
  input wire logic [7:0] mode_rdata,
  input wire logic       index_wr,
  input wire logic [7:0] index_wdata,
  input wire logic [7:0] index_rdata,
  input wire logic       window_wr,
  input wire logic [7:0] window_wdata,
  input wire logic [7:0] window_rdata,
  input wire logic       lin_rx,
  input wire logic       lin_tx,
  input wire logic       irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_reset_idle: assert property (
    $rose(rst_n) |-> lin_tx && !irq && mode_rdata == 8'h00) else $error("bad state after reset");
  a_mode_readback: assert property (
    mode_wr |=> mode_rdata[7:5] == $past(mode_wdata[7:5])) else $error("mode bits not stored");
  a_index_readback: assert property (
    index_wr |=> index_rdata == $past(index_wdata)) else $error("index not stored");
  a_size_window: assert property (
    window_wr && !index_wr && index_rdata == 8'h0b |=> window_rdata == $past(window_wdata))
    else $error("size register not written through window");
  a_mul_window: assert property (
    window_wr && !index_wr && index_rdata == 8'h0d |=> window_rdata == $past(window_wdata))
    else $error("multiplier register not written through window");
  a_ctrl_strobes: assert property (
    index_rdata == 8'h08 |-> window_rdata[3:2] == 2'b00 && !window_rdata[0])
    else $error("control strobe reads back set");
  a_irq_clear: assert property (
    window_wr && index_rdata == 8'h08 && window_wdata[3] |=> !irq) else $error("irq not cleared");
  a_idle_high: assert property (
    !mode_rdata[7] && !$past(mode_rdata[7]) |-> lin_tx) else $error("bus driven while inactive");
  a_master_drive: assert property (
    $fell(lin_tx) |-> mode_rdata[7:6] == 2'b11) else $error("bus driven outside master role");
endmodule // lin_node_sva
bind lin_node lin_node_sva u_lin_node_sva (.clk_sys, .rst_n, .mode_wr, .mode_wdata, .mode_rdata,
  .index_wr, .index_wdata, .index_rdata, .window_wr, .window_wdata, .window_rdata, .lin_rx,
  .lin_tx, .irq);

// *** tb/lin_partner.sv ***
// Far-side LIN node: wired-AND bus with pull-up, listening only
`timescale 1ns/1ps
module lin_partner (
  input  wire logic lin_tx,
  output wire logic lin_rx
);
  // Stays recessive: master transmit frames need no answer from this node
  logic drive_low = 1'b0;
  assign lin_rx = lin_tx & ~drive_low;
endmodule // lin_partner

// *** tb/lin_node_bench.sv ***
// Self-checking bench for the LIN node setup and bit rate
`timescale 1ns/1ps
module lin_node_bench;
  logic       clk_sys      = 1'b0;
  logic       rst_n        = 1'b1;
  logic       mode_wr      = 1'b0;
  logic [7:0] mode_wdata   = 8'h00;
  logic       index_wr     = 1'b0;
  logic [7:0] index_wdata  = 8'h00;
  logic       window_wr    = 1'b0;
  logic [7:0] window_wdata = 8'h00;
  wire  [7:0] mode_rdata;
  wire  [7:0] index_rdata;
  wire  [7:0] window_rdata;
  wire        lin_rx;
  wire        lin_tx;
  wire        irq;
  int         miscompares  = 0;
  int         checked      = 0;
  int         cycles       = 0;
  int         n;
  logic [7:0] b            = 8'h00;
  always #10 clk_sys = ~clk_sys;
  lin_node u_lin_node (.clk_sys, .rst_n, .mode_wr, .mode_wdata, .mode_rdata, .index_wr,
    .index_wdata, .index_rdata, .window_wr, .window_wdata, .window_rdata, .lin_rx, .lin_tx, .irq);
  lin_partner u_lin_partner (.lin_tx, .lin_rx);
  task report_and_stop;
    if (miscompares == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One strobe per call, with an idle cycle between calls
  task put(input int sel, input logic [7:0] v);
    @(posedge clk_sys);
    mode_wdata <= v;
    index_wdata <= v;
    window_wdata <= v;
    mode_wr <= (sel == 0);
    index_wr <= (sel == 1);
    window_wr <= (sel == 2);
    @(posedge clk_sys);
    {mode_wr, index_wr, window_wr} <= 3'b000;
  endtask
  task wreg(input logic [7:0] i, input logic [7:0] v);
    put(1, i);
    put(2, v);
  endtask
  task rreg(input logic [7:0] i, input logic [7:0] exp);
    put(1, i);
    #1 chk(window_rdata, exp);
  endtask
  // Length in clocks of the next stretch of the bus at level lvl
  task seg(input logic lvl);
    n = 0;
    while (lin_tx !== lvl) @(negedge clk_sys);
    while (lin_tx === lvl) begin
      n++;
      @(negedge clk_sys);
    end
  endtask
  // Start a frame and time the sync field after break and delimiter
  task frame_bit(input int exp);
    wreg(8'h08, 8'h21);
    seg(1'b0);
    chk(16'(n), 16'(14 * exp)); // Break is 14 bits
    seg(1'b1);
    seg(1'b0);
    chk(16'(n), 16'(exp));
    seg(1'b1);
    chk(16'(n), 16'(exp));
  endtask
  // Sample one byte at mid-bit, 400 clocks a bit, after skip clocks to its start centre
  task grab(input int skip);
    repeat (skip) @(negedge clk_sys);
    for (int j = 0; j < 8; j++) begin
      repeat (400) @(negedge clk_sys);
      b[j] = lin_tx;
    end
  endtask
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      miscompares++;
      report_and_stop;
    end
  end
  initial begin
    rst_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1 chk({mode_rdata, index_rdata}, 16'h0000);
    rreg(8'h0c, 8'hc8);
    rreg(8'h0d, 8'h00);
    put(0, 8'h80);
    wreg(8'h08, 8'h01);
    repeat (50) @(posedge clk_sys);
    #1 chk(lin_tx, 1);
    rreg(8'h08, 8'h00);
    put(0, 8'he0);
    #1 chk(mode_rdata, 8'he0);
    put(0, 8'hc0); // Master with manual rate
    wreg(8'h0d, 8'h00); // Factors already rounded down
    wreg(8'h0c, 8'hc8);
    wreg(8'h0b, 8'h81);
    rreg(8'h0b, 8'h81);
    wreg(8'h00, 8'h5a);
    wreg(8'h01, 8'ha5);
    rreg(8'h00, 8'h5a);
    rreg(8'h01, 8'ha5);
    frame_bit(400);
    // Rest of sync field, then protected id of identifier 0, data byte, checksum
    grab(3400);
    chk(b, 8'h80);
    grab(800);
    chk(b, 8'h5a);
    grab(800);
    chk(b, 8'h25); // Enhanced: inverse of 0x80 + 0x5a
    for (int k = 0; k < 40000 && irq !== 1'b1; k++) @(negedge clk_sys);
    chk(irq, 1);
    rreg(8'h09, 8'h03);
    wreg(8'h08, 8'h0c);
    #1 chk(irq, 0);
    rreg(8'h08, 8'h00);
    // Prescale 1 and divider bit 8 set: 4 * 256 clocks a bit
    wreg(8'h0d, 8'h41);
    rreg(8'h0d, 8'h41);
    wreg(8'h0c, 8'h00);
    frame_bit(1024);
    put(0, 8'h00);
    repeat (3) @(negedge clk_sys);
    chk(lin_tx, 1);
    report_and_stop;
  end
endmodule // lin_node_bench
